/* File: core/pwmc_channel.sv */
// Purpose: one pulse output channel, single pulse or pulse-width modulation
// Assumes: all inputs but reset_n synchronous to clk; strobes are single cycles
// Notes:   high time and gap are recomputed every cycle from live settings
`timescale 1ns/1ps

module pwmc_channel
  import pwmc_pkg::*;
#(
  parameter int unsigned FINE_CYC   = FINE_STEP_CYC,
  parameter int unsigned COARSE_CYC = COARSE_STEP_CYC
)
(
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [2:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        aux_gate_input,
  output logic             pulse_out,
  output logic             sequence_active_flag,
  output logic             run_request_echo
);

  // phase of the output sequence
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_HIGH,
    ST_LOW
  } pwmc_state_type;

  pwmc_ctrl_type   ctrl_reg;
  pwmc_status_type status;
  pwmc_state_type  state_reg;
  logic [15:0]     value_reg;
  logic [15:0]     period_reg;
  logic [15:0]     minp_reg;
  logic [15:0]     delay_reg;
  logic [7:0]      pfactor_reg;
  logic [7:0]      dfactor_reg;
  logic            run_prev_reg;
  logic            aux_prev_reg;
  logic [15:0]     presc_reg;
  logic [23:0]     elapsed_reg;
  logic [23:0]     delay_cap_reg;
  logic            tick;
  logic            start_evt;
  logic            run_rise;
  logic            aux_rise;
  logic [23:0]     period_sub;
  logic [23:0]     minp_sub;
  logic [23:0]     delay_sub;
  logic [23:0]     high_raw;
  logic [23:0]     high_t;
  logic [23:0]     gap_t;
  logic [15:0]     step_last;

  // lower bound of a time setting for the selected base
  function automatic logic [15:0] floor_units(
    input logic [15:0] u,
    input logic        coarse
  );
    logic [15:0] lim;
    lim = coarse ? COARSE_MIN_UNITS : FINE_MIN_UNITS;
    return (u < lim) ? lim : u;
  endfunction

  // units of the time base to sub-steps
  function automatic logic [23:0] to_sub(input logic [15:0] u);
    logic [23:0] wide;
    wide = {8'h00, u};
    return 24'(wide * SUB_PER_UNIT);
  endfunction

  // units times a factor weighted in tenths gives sub-steps
  function automatic logic [23:0] times_factor(
    input logic [15:0] u,
    input logic [7:0]  f
  );
    logic [23:0] wide;
    wide = {8'h00, u};
    return 24'(wide * {16'h0000, f});
  endfunction

  // output value held inside the selected format range
  function automatic logic [15:0] clamp_value(
    input logic [15:0] v,
    input logic        analog
  );
    logic [15:0] top;
    top = analog ? ANALOG_FULL : PERMILL_FULL;
    return (v > top) ? top : v;
  endfunction

  // proportional high time; the divider is a constant per format
  function automatic logic [23:0] scale_high(
    input logic [15:0] v,
    input logic [23:0] p,
    input logic        analog
  );
    // value times a 24-bit period needs 40 bits before the divide
    logic [39:0] prod;
    prod = {24'h000000, v} * {16'h0000, p};
    if (analog)
      return 24'(prod / {24'h000000, ANALOG_FULL});
    else
      return 24'(prod / {24'h000000, PERMILL_FULL});
  endfunction

  // register writes; run_request is a plain software level
  // factors act live, only the delay factor is caught at start
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl_reg    <= CTRL_RST;
      value_reg   <= VALUE_RST;
      period_reg  <= PERIOD_RST;
      minp_reg    <= MINP_RST;
      delay_reg   <= DELAY_RST;
      pfactor_reg <= FACTOR_RST;
      dfactor_reg <= FACTOR_RST;
    end
    else if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_CTRL:    ctrl_reg    <= pwmc_ctrl_type'(reg_wdata[5:0]);
        ADDR_VALUE:   value_reg   <= reg_wdata;
        ADDR_PERIOD:  period_reg  <= reg_wdata;
        ADDR_MINP:    minp_reg    <= reg_wdata;
        ADDR_DELAY:   delay_reg   <= reg_wdata;
        ADDR_PFACTOR: pfactor_reg <= reg_wdata[7:0];
        ADDR_DFACTOR: dfactor_reg <= reg_wdata[7:0];
        ADDR_STATUS:  ; // read only
      endcase
    end
  end

  // status word; echo is the stored run request itself
  // levels are shown live, with no update lag
  assign run_request_echo = ctrl_reg.run_request;
  assign status.run_request_echo = ctrl_reg.run_request;
  assign status.aux_level        = aux_gate_input;
  assign status.pulse_level      = pulse_out;
  assign status.sequence_active  = sequence_active_flag;

  // read data stand in the cycle after the strobe only
  // unused upper bits of narrow registers read as zero
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      reg_rdata <= 16'h0000;
    else if (!reg_rd)
      reg_rdata <= 16'h0000;
    else
    begin
      unique case (reg_addr)
        ADDR_CTRL:    reg_rdata <= {10'h000, ctrl_reg};
        ADDR_VALUE:   reg_rdata <= value_reg;
        ADDR_PERIOD:  reg_rdata <= period_reg;
        ADDR_MINP:    reg_rdata <= minp_reg;
        ADDR_DELAY:   reg_rdata <= delay_reg;
        ADDR_PFACTOR: reg_rdata <= {8'h00, pfactor_reg};
        ADDR_DFACTOR: reg_rdata <= {8'h00, dfactor_reg};
        ADDR_STATUS:  reg_rdata <= {12'h000, status};
      endcase
    end
  end

  // edge history of run request and gate input
  // cleared to the idle level, so reset brings no false edge
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      run_prev_reg <= 1'b0;
      aux_prev_reg <= 1'b0;
    end
    else
    begin
      run_prev_reg <= ctrl_reg.run_request;
      aux_prev_reg <= aux_gate_input;
    end
  end

  // an edge is a level high now that was low one cycle ago
  assign run_rise = ctrl_reg.run_request && !run_prev_reg;
  assign aux_rise = aux_gate_input && !aux_prev_reg;

  // start only from idle, so later edges fall on deaf ears
  assign start_evt = (state_reg == ST_IDLE)
                  && ctrl_reg.run_request
                  && !ctrl_reg.manual_override
                  && (ctrl_reg.gate_hw ? aux_rise
                                       : run_rise);

  // sub-step prescaler, realigned at start so the delay is exact
  assign step_last = ctrl_reg.coarse_base
                   ? 16'(COARSE_CYC - 1)
                   : 16'(FINE_CYC - 1);
  // one tick per sub-step; after a base change a count past the new last step restarts at zero
  assign tick = (presc_reg == step_last);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      presc_reg <= 16'h0000;
    else if (start_evt || tick || presc_reg > step_last)
      presc_reg <= 16'h0000;
    else
      presc_reg <= presc_reg + 16'h0001;
  end

  // effective period, minimum and delay in sub-steps
  always_comb
  begin
    // the floor applies before the factor, so 0 or 1 acts as 2
    period_sub = times_factor((period_reg < PERIOD_MIN_UNITS)
                              ? PERIOD_MIN_UNITS : period_reg,
                              pfactor_reg);
    minp_sub = to_sub(floor_units(minp_reg,
                                  ctrl_reg.coarse_base));
    // under the base's floor (2 fine units, 1 coarse unit), or with factor 0, no delay at all
    if (dfactor_reg == 8'h00
        || delay_reg < floor_units(16'h0000, ctrl_reg.coarse_base))
      delay_sub = 24'h000000;
    else
      delay_sub = times_factor(delay_reg, dfactor_reg);
  end

  // high time and gap follow the live value every cycle
  always_comb
  begin
    high_raw = scale_high(clamp_value(value_reg,
                                      ctrl_reg.format_analog),
                          period_sub,
                          ctrl_reg.format_analog);
    if (ctrl_reg.single_mode)
    begin
      // below the floor no pulse is produced
      if (value_reg < floor_units(16'h0000, ctrl_reg.coarse_base))
        high_t = 24'h000000;
      else
        high_t = to_sub(value_reg);
    end
    else if (high_raw < minp_sub)
      high_t = 24'h000000;
    else if (period_sub < minp_sub || high_raw > period_sub - minp_sub)
      high_t = period_sub;
    else
      high_t = high_raw;
    // a zero gap keeps the output high across period bounds
    gap_t = period_sub - high_t;
  end

  // sequence control, phase timing and output level
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_reg            <= ST_IDLE;
      elapsed_reg          <= 24'h000000;
      delay_cap_reg        <= 24'h000000;
      pulse_out            <= 1'b0;
      sequence_active_flag <= 1'b0;
    end
    // clearing run wins over every phase, so no late pulse escapes
    else if (state_reg != ST_IDLE && !ctrl_reg.run_request)
    begin
      state_reg            <= ST_IDLE;
      pulse_out            <= 1'b0;
      sequence_active_flag <= 1'b0;
    end
    else
    begin
      unique case (state_reg)
        ST_IDLE:
        begin
          // only idle listens for a start, so later edges are ignored
          if (start_evt)
          begin
            sequence_active_flag <= 1'b1;
            elapsed_reg          <= 24'h000000;
            // delay factor is frozen for this sequence
            delay_cap_reg        <= delay_sub;
            if (delay_sub == 24'h000000)
            begin
              state_reg <= ST_HIGH;
              pulse_out <= (high_t != 24'h000000);
            end
            else
              state_reg <= ST_DELAY;
          end
        end
        ST_DELAY:
        begin
          // the prescaler was realigned at start, so the delay is exact
          if (elapsed_reg >= delay_cap_reg)
          begin
            state_reg   <= ST_HIGH;
            elapsed_reg <= 24'h000000;
            pulse_out   <= (high_t != 24'h000000);
          end
          else if (tick)
            elapsed_reg <= elapsed_reg + 24'h000001;
        end
        ST_HIGH:
        begin
          // a shrinking high time ends the pulse early
          if (elapsed_reg >= high_t)
          begin
            elapsed_reg <= 24'h000000;
            // a single pulse closes the sequence; restart needs an edge
            if (ctrl_reg.single_mode)
            begin
              state_reg            <= ST_IDLE;
              pulse_out            <= 1'b0;
              sequence_active_flag <= 1'b0;
            end
            else if (gap_t != 24'h000000)
            begin
              state_reg <= ST_LOW;
              pulse_out <= 1'b0;
            end
          end
          else if (tick)
            elapsed_reg <= elapsed_reg + 24'h000001;
        end
        ST_LOW:
        begin
          // gap compared live: one period stretches or shrinks
          if (elapsed_reg >= gap_t)
          begin
            elapsed_reg <= 24'h000000;
            if (high_t != 24'h000000)
            begin
              state_reg <= ST_HIGH;
              pulse_out <= 1'b1;
            end
          end
          else if (tick)
            elapsed_reg <= elapsed_reg + 24'h000001;
        end
      endcase
    end
  end

endmodule

/* File: core/pwmc_pkg.sv */
// Purpose: constants and carriers for the pulse-width modulation channel
// Assumes: 40 MHz clock, 16-bit register port with 3 address bits
// Notes:   times run in sub-steps of one tenth of the selected time base
package pwmc_pkg;

  // clock and time base
  localparam int unsigned CLK_PERIOD_NS  = 25;
  localparam int unsigned FINE_STEP_NS   = 10_000;   // 0.1 ms / 10
  localparam int unsigned COARSE_STEP_NS = 100_000;  // 1 ms / 10
  localparam int unsigned FINE_STEP_CYC  = FINE_STEP_NS / CLK_PERIOD_NS;
  localparam int unsigned COARSE_STEP_CYC = COARSE_STEP_NS / CLK_PERIOD_NS;
  localparam logic [23:0] SUB_PER_UNIT   = 24'h00000A; // factor weight 0.1

  // register offsets
  localparam logic [2:0] ADDR_CTRL    = 3'h0;
  localparam logic [2:0] ADDR_VALUE   = 3'h1;
  localparam logic [2:0] ADDR_PERIOD  = 3'h2;
  localparam logic [2:0] ADDR_MINP    = 3'h3;
  localparam logic [2:0] ADDR_DELAY   = 3'h4;
  localparam logic [2:0] ADDR_PFACTOR = 3'h5;
  localparam logic [2:0] ADDR_DFACTOR = 3'h6;
  localparam logic [2:0] ADDR_STATUS  = 3'h7;

  // value ranges and reset values
  localparam logic [15:0] PERMILL_FULL = 16'h03E8;   // 1000
  localparam logic [15:0] ANALOG_FULL  = 16'h6C00;   // 27648
  localparam logic [15:0] FINE_MIN_UNITS   = 16'h0002;
  localparam logic [15:0] COARSE_MIN_UNITS = 16'h0001;
  localparam logic [15:0] PERIOD_MIN_UNITS = 16'h0002;
  localparam logic [15:0] VALUE_RST    = 16'h0000;
  localparam logic [15:0] PERIOD_RST   = 16'h4E20;   // 20000
  localparam logic [15:0] MINP_RST     = 16'h2710;   // 10000
  localparam logic [15:0] DELAY_RST    = 16'h0000;
  localparam logic [7:0]  FACTOR_RST   = 8'h0A;      // 1.0

  // control register layout, bit 0 is run_request
  typedef struct packed {
    logic format_analog;
    logic gate_hw;
    logic coarse_base;
    logic single_mode;
    logic manual_override;
    logic run_request;
  } pwmc_ctrl_type;

  localparam pwmc_ctrl_type CTRL_RST = '0;

  // status register layout, bit 0 is sequence_active_flag
  typedef struct packed {
    logic run_request_echo;
    logic aux_level;
    logic pulse_level;
    logic sequence_active;
  } pwmc_status_type;

endpackage

/* File: tb/pwmc_channel_props.sv */
// Purpose: port checker for the modulation channel
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes:   keeps a shadow of the control word to know the mode
`timescale 1ns/1ps
module pwmc_channel_props
  import pwmc_pkg::*;
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic [2:0]  reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic        aux_gate_input,
  input wire logic        pulse_out,
  input wire logic        sequence_active_flag,
  input wire logic        run_request_echo
);
  pwmc_ctrl_type ctrl_reg;
  logic          ctrl_wr;

  // control writes, shared by the shadow and the properties
  assign ctrl_wr = reg_wr && reg_addr == ADDR_CTRL;

  // shadow of the control word, updated at the same edge as the design
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      ctrl_reg <= CTRL_RST;
    else if (ctrl_wr)
      ctrl_reg <= pwmc_ctrl_type'(reg_wdata[5:0]);
  end

  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_echo;
    ctrl_wr |=> run_request_echo == $past(reg_wdata[0]);
  endproperty
  a_echo: assert property (p_echo)
    else $error("run echo differs from written bit");

  property p_start;
    ctrl_wr && reg_wdata[0] && !reg_wdata[1] && !reg_wdata[2] &&
      !reg_wdata[4] && !run_request_echo && !sequence_active_flag
      |-> ##2 sequence_active_flag;
  endproperty
  a_start: assert property (p_start)
    else $error("sequence did not start two cycles after run");

  property p_abort;
    $fell(run_request_echo) |-> ##[1:2] !sequence_active_flag && !pulse_out;
  endproperty
  a_abort: assert property (p_abort)
    else $error("clearing run did not stop the sequence");

  property p_idle;
    !run_request_echo [*3] |-> !sequence_active_flag && !pulse_out;
  endproperty
  a_idle: assert property (p_idle)
    else $error("output active without run request");

  property p_cause;
    $rose(sequence_active_flag)
      |-> run_request_echo && !ctrl_reg.manual_override;
  endproperty
  a_cause: assert property (p_cause)
    else $error("sequence started without a valid run request");

  property p_gate_start;
    ctrl_reg.gate_hw && run_request_echo && !ctrl_reg.manual_override &&
      !sequence_active_flag && $rose(aux_gate_input)
      |-> ##[1:3] sequence_active_flag;
  endproperty
  a_gate_start: assert property (p_gate_start)
    else $error("gate edge did not start the sequence");

  property p_gate_cause;
    $rose(sequence_active_flag) && ctrl_reg.gate_hw |-> $past(aux_gate_input);
  endproperty
  a_gate_cause: assert property (p_gate_cause)
    else $error("gated start without a gate edge");

  property p_rdata;
    reg_rdata != 16'h0000 |-> $past(reg_rd);
  endproperty
  a_rdata: assert property (p_rdata)
    else $error("read data outside the answer cycle");

  property p_pulse_active;
    pulse_out |-> sequence_active_flag;
  endproperty
  a_pulse_active: assert property (p_pulse_active)
    else $error("pulse output high while no sequence runs");
endmodule

/* File: tb/pwmc_actuator.sv */
// Purpose: actuator model, measures high and low times of the output
// Assumes: pulse_out is sampled on rising edges of clk
// Notes:   lengths in clocks; run_len counts the current level
`timescale 1ns/1ps
module pwmc_actuator
(
  input wire logic        clk,
  input wire logic        reset_n,
  input wire logic        pulse_out,
  output logic     [31:0] high_len,
  output logic     [31:0] low_len,
  output logic     [31:0] run_len
);
  logic level_reg;

  // a load only listens, so it places no demand on the channel
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      level_reg <= 1'h0;
      high_len  <= 32'h0;
      low_len   <= 32'h0;
      run_len   <= 32'h0;
    end
    else
    begin
      level_reg <= pulse_out;
      run_len   <= (pulse_out != level_reg) ? 32'h1 : run_len + 32'h1;
      if (pulse_out != level_reg && level_reg)
        high_len <= run_len;
      if (pulse_out != level_reg && !level_reg)
        low_len <= run_len;
    end
  end
endmodule

/* File: tb/pwmc_channel_test.sv */
// Purpose: self-checking bench for the modulation channel
// Assumes: sub-steps shortened to 4 clocks fine and 8 coarse
// Notes:   table rows first, then delay, abort, gate and single pulse
`timescale 1ns/1ps
module pwmc_channel_test import pwmc_pkg::*;;
  localparam int P = 100; // 10 units times factor 10, in sub-steps
  localparam int M = 20;  // 2 units, in sub-steps
  typedef struct packed {
    logic        coarse;
    logic        analog;
    logic [15:0] value;
  } pwmc_row_type;
  localparam pwmc_row_type ROWS [9] = '{'{1'h0, 1'h0, 16'h01F4},
    '{1'h0, 1'h0, 16'h0064}, '{1'h0, 1'h0, 16'h00C8},
    '{1'h0, 1'h0, 16'h0352}, '{1'h0, 1'h0, 16'h05DC},
    '{1'h0, 1'h0, 16'h0000}, '{1'h0, 1'h1, 16'h3600},
    '{1'h0, 1'h1, 16'h7530}, '{1'h1, 1'h0, 16'h01F4}};
  logic        clk, reset_n, reg_wr, reg_rd, aux_gate_input, pulse_out;
  logic        sequence_active_flag, run_request_echo;
  logic [2:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] high_len, low_len, run_len;
  int          n_fail, total_checks, waited, cyc, h;

  pwmc_channel #(.FINE_CYC(4), .COARSE_CYC(8)) i_pwmc_channel (
    .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .aux_gate_input(aux_gate_input),
    .pulse_out(pulse_out), .sequence_active_flag(sequence_active_flag),
    .run_request_echo(run_request_echo));
  pwmc_actuator i_pwmc_actuator (.clk(clk), .reset_n(reset_n),
    .pulse_out(pulse_out), .high_len(high_len), .low_len(low_len),
    .run_len(run_len));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %0h got %0h", n, e, g);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
  endtask

  // read data is valid only in the cycle after the strobe
  task automatic rchk(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    chk("rdata", {16'h0000, e}, {16'h0000, reg_rdata});
  endtask

  // bounded wait on the output (sel 0) or the active flag (sel 1)
  task automatic wait_for(input logic sel, input logic lvl);
    waited = 0;
    while ((sel ? sequence_active_flag : pulse_out) !== lvl &&
           waited < 4000)
    begin
      @(posedge clk);
      #1;
      waited++;
    end
    if (waited >= 4000)
    begin
      chk("wait", 32'h0, 32'h1);
      summarize();
    end
  endtask

  function automatic int exp_h(input int v, input logic an);
    int full;
    int t;
    full = an ? int'(ANALOG_FULL) : int'(PERMILL_FULL);
    t    = (v > full) ? full : v;
    t    = t * P / full;
    if (t < M)
      t = 0;
    if (t > P - M)
      t = P;
    return t;
  endfunction

  initial
  begin
    clk            = 1'h0;
    reset_n        = 1'h0;
    reg_wr         = 1'h0;
    reg_rd         = 1'h0;
    reg_addr       = 3'h0;
    reg_wdata      = 16'h0000;
    aux_gate_input = 1'h0;
    n_fail         = 0;
    total_checks   = 0;
    repeat (6) @(posedge clk);
    reset_n <= 1'h1;
    rchk(ADDR_PERIOD, 16'h4E20);
    rchk(ADDR_MINP, 16'h2710);
    rchk(ADDR_PFACTOR, 16'h000A);
    wr(ADDR_STATUS, 16'hFFFF);
    rchk(ADDR_STATUS, 16'h0000);
    wr(ADDR_PERIOD, 16'h000A);
    wr(ADDR_MINP, 16'h0002);
    // each row restarts the channel and measures settled periods
    for (int i = 0; i < 9; i++)
    begin
      wr(ADDR_CTRL, 16'h0000);
      wr(ADDR_VALUE, ROWS[i].value);
      wr(ADDR_CTRL, {10'h000, ROWS[i].analog, 1'h0, ROWS[i].coarse,
                     3'h1});
      cyc = ROWS[i].coarse ? 8 : 4;
      h   = exp_h(int'(ROWS[i].value), ROWS[i].analog);
      repeat (300 * cyc + 40) @(posedge clk);
      #1;
      if (h == 0 || h == P)
      begin
        chk("level", 32'(h == P), 32'(pulse_out));
        chk("steady", 32'h1, 32'(run_len >= 2 * P * cyc));
      end
      else
      begin
        chk("high_len", h * cyc, high_len);
        chk("low_len", (P - h) * cyc, low_len);
      end
    end
    // on-delay of 50 sub-steps, then abort while pulsing
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_VALUE, 16'h01F4);
    wr(ADDR_DELAY, 16'h0005);
    wr(ADDR_CTRL, 16'h0001);
    wait_for(1'h1, 1'h1);
    chk("delay_out", 32'h0, 32'(pulse_out));
    wait_for(1'h0, 1'h1);
    chk("delay", 32'h1, 32'(waited >= 199 && waited <= 202));
    rchk(ADDR_STATUS, 16'h000B);
    wr(ADDR_CTRL, 16'h0000);
    repeat (3) @(posedge clk);
    #1;
    chk("abort", 32'h0, {30'h0, sequence_active_flag, pulse_out});
    wr(ADDR_DELAY, 16'h0000);
    // override held high must block the start
    wr(ADDR_CTRL, 16'h0003);
    repeat (20) @(posedge clk);
    #1;
    chk("override", 32'h0, 32'(sequence_active_flag));
    wr(ADDR_CTRL, 16'h0000);
    // gated start, then a gate edge in the gap must not restart
    wr(ADDR_CTRL, 16'h0011);
    repeat (20) @(posedge clk);
    #1;
    chk("gate_wait", 32'h0, 32'(sequence_active_flag));
    @(posedge clk) aux_gate_input <= 1'h1;
    wait_for(1'h1, 1'h1);
    wait_for(1'h0, 1'h0);
    repeat (50) @(posedge clk);
    aux_gate_input <= 1'h0;
    @(posedge clk) aux_gate_input <= 1'h1;
    wait_for(1'h0, 1'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("gap_kept", (P - 50) * 4, low_len);
    // single pulse of 3 units, sequence ends after it
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_VALUE, 16'h0003);
    wr(ADDR_CTRL, 16'h0005);
    wait_for(1'h0, 1'h1);
    wait_for(1'h0, 1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("single_len", 32'd121, high_len);
    chk("single_end", 32'h0, 32'(sequence_active_flag));
    // value changes in the gap: shorter, then longer, one period each
    wr(ADDR_CTRL, 16'h0000);
    wr(ADDR_VALUE, 16'h01F4);
    wr(ADDR_CTRL, 16'h0001);
    wait_for(1'h0, 1'h1);
    wait_for(1'h0, 1'h0);
    wr(ADDR_VALUE, 16'h0320);
    wait_for(1'h0, 1'h1);
    wait_for(1'h0, 1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("gap_short", 32'h50, low_len);
    chk("high_new", 32'h140, high_len);
    wr(ADDR_VALUE, 16'h00C8);
    wait_for(1'h0, 1'h1);
    wait_for(1'h0, 1'h0);
    repeat (2) @(posedge clk);
    #1;
    chk("gap_long", 32'h140, low_len);
    chk("high_low", 32'h50, high_len);
    wr(ADDR_CTRL, 16'h0000);
    summarize();
  end
endmodule

bind pwmc_channel pwmc_channel_props i_pwmc_channel_props (
  .clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .aux_gate_input(aux_gate_input),
  .pulse_out(pulse_out), .sequence_active_flag(sequence_active_flag),
  .run_request_echo(run_request_echo));
